// [rtl/gpee_pkg.sv]
package gpee_pkg;

    // i/o offsets from the power-management base
    localparam logic [7:0]  GROUP0_ENABLES_OFFSET = 8'h2A;
    localparam logic [7:0]  GROUP1_STATUS_OFFSET  = 8'h2C;

    localparam logic [15:0] GROUP0_ENABLES_RESET  = 16'h0000;
    localparam logic [15:0] GROUP1_STATUS_RESET   = 16'h0000;
    localparam logic [15:0] GROUP0_WRITABLE_MASK  = 16'h3D7D;
    localparam logic [15:0] GP_INPUT_IMPLEMENTED  = 16'hF7FF;
    localparam logic [15:0] WAKE_SOURCE_MASK      = 16'h3938;

    // enable and status bit positions of the first group
    localparam int THERMAL_EVENT_BIT    = 0;
    localparam int THERMAL_POLARITY_BIT = 2;
    localparam int USB_ONE_BIT          = 3;
    localparam int USB_TWO_BIT          = 4;
    localparam int CODEC_BIT            = 5;
    localparam int TCO_BIT              = 6;
    localparam int RESUME_WELL_TOP      = 7;
    localparam int RTC_WELL_LOW         = 8;
    localparam int RING_BIT             = 8;
    localparam int BATTERY_LOW_BIT      = 10;
    localparam int MGMT_EVENT_BIT       = 11;
    localparam int USB_THREE_BIT        = 12;
    localparam int BUS0_MGMT_BIT        = 13;

    // per-input routing code, two bits per general-purpose input
    localparam logic [1:0] ROUTE_NONE        = 2'h0;
    localparam logic [1:0] ROUTE_SYSTEM_MGMT = 2'h1;
    localparam logic [1:0] ROUTE_ACPI        = 2'h2;

    typedef enum logic [2:0] {
        SLEEP_S0 = 3'b000,
        SLEEP_S1 = 3'b001,
        SLEEP_S2 = 3'b010,
        SLEEP_S3 = 3'b011,
        SLEEP_S4 = 3'b100,
        SLEEP_S5 = 3'b101
    } gpee_sleep_type;

    typedef enum logic [1:0] {
        ENTRY_SLEEP_COMMAND = 2'b00,
        ENTRY_POWER_FAIL    = 2'b01,
        ENTRY_OVERRIDE      = 2'b10
    } gpee_s5_entry_type;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  offset;
        logic [1:0]  byteEnable;
        logic [15:0] data;
    } gpee_io_req_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } gpee_io_rsp_type;

    function automatic logic offsetHit(input gpee_io_req_type req, input logic [7:0] offset);
        return req.offset == offset;
    endfunction

    function automatic logic [15:0] laneMask(input logic [1:0] byteEnable);
        return {{8{byteEnable[1]}}, {8{byteEnable[0]}}};
    endfunction

    function automatic logic [15:0] routeMask(input logic [31:0] routing, input logic [1:0] code);
        logic [15:0] mask;
        mask = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            mask[i] = routing[2*i +: 2] == code;
        end
        return mask;
    endfunction

endpackage

// [rtl/gpee_gp_status.sv]
`timescale 1ns/1ps
module gpee_gp_status
    import gpee_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [15:0] pinLevel,
    input  wire logic [15:0] isInput,
    input  wire logic [15:0] invert,
    input  wire logic [15:0] clearMask,
    output wire logic [15:0] pinActive,
    output logic      [15:0] flag
);

    logic [15:0] next_flag;

    // active low unless inverted, only when configured as input
    assign pinActive = isInput & (pinLevel ^ ~invert);

    // an active pin keeps its bit set through a clear
    assign next_flag = GP_INPUT_IMPLEMENTED
                     & (pinActive | (flag & ~clearMask));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= GROUP1_STATUS_RESET;
        end else if (ce) begin
            flag <= next_flag;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_gp_flag_hold: assert property (ce |=> (($past(pinActive) & GP_INPUT_IMPLEMENTED & ~flag) == 16'h0000))
        else $error("active input left its flag clear");

    a_gp_unimplemented_zero: assert property ((flag & ~GP_INPUT_IMPLEMENTED) == 16'h0000)
        else $error("flag set for an absent input");

    a_gp_clear_idle: assert property (ce && |(clearMask & flag & ~pinActive) |=>
        ((flag & $past(clearMask & ~pinActive)) == 16'h0000))
        else $error("clear of an idle input did not take");

endmodule

// [rtl/gpee_event_gate.sv]
`timescale 1ns/1ps
module gpee_event_gate
    import gpee_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              rtc_well_reset,
    input  wire logic              ce,
    input  wire gpee_io_req_type   ioRequest,
    output gpee_io_rsp_type        ioResponse,
    input  wire logic              pwrButtonOverride,
    input  wire logic              thermalPin,
    input  wire logic              batteryLowPin,
    input  wire logic              acpiRoutingSelect,
    input  wire gpee_sleep_type    sleepState,
    input  wire gpee_s5_entry_type s5Entry,
    input  wire logic              bus0MgmtEventFlag,
    input  wire logic              usbCtrlThreeWakeFlag,
    input  wire logic              mgmtEventFlag,
    input  wire logic              ringWakeFlag,
    input  wire logic              codecWakeFlag,
    input  wire logic              usbCtrlTwoWakeFlag,
    input  wire logic              usbCtrlOneWakeFlag,
    input  wire logic              tcoAcpiIrqSet,
    input  wire logic              tcoAcpiIrqClear,
    input  wire logic              thermalFlagClear,
    input  wire logic [15:0]       gpInputPin,
    input  wire logic [15:0]       gpInputIsInput,
    input  wire logic [15:0]       gpInputInvert,
    input  wire logic [15:0]       gpInputEnable,
    input  wire logic [31:0]       gpInputRouting,
    output wire logic [15:0]       eventGroup0Enables,
    output wire logic [15:0]       gpInputFlag,
    output logic                   thermalFlag,
    output logic                   tcoAcpiIrqFlag,
    output logic      [15:0]       groupZeroRequest,
    output logic      [15:0]       groupOneRequest,
    output logic                   wakeRequest,
    output logic                   acpiEventRequest,
    output logic                   systemMgmtRequest
);

    logic [7:0]  enablesResume;
    logic [15:8] enablesRtc;
    logic        batteryLowPrev;

    wire  logic        enablesHit;
    wire  logic        statusHit;
    wire  logic [15:0] writeLanes;
    wire  logic        enablesWrite;
    wire  logic [15:0] next_enables;
    wire  logic [15:0] group1Clear;
    wire  logic [15:0] gpActive;
    wire  logic        thermalActive;
    wire  logic        next_thermalFlag;
    wire  logic        next_tcoAcpiIrqFlag;
    wire  logic [15:0] group0Status;
    wire  logic [15:0] group0Pending;
    wire  logic [15:0] group1Pending;
    wire  logic [15:0] gpAcpiRoute;
    wire  logic [15:0] gpMgmtRoute;
    wire  logic        sleeping;
    wire  logic        inS5;
    wire  logic        bus0WakeAllowed;
    wire  logic        mgmtWakeAllowed;
    wire  logic        next_wakeRequest;
    wire  logic        batteryLowFall;
    wire  logic        batteryLowEvent;
    wire  logic        routedEvent;
    wire  logic        next_acpiEventRequest;
    wire  logic        next_systemMgmtRequest;
    wire  logic [15:0] readData;

    // register decode
    assign enablesHit   = offsetHit(ioRequest, GROUP0_ENABLES_OFFSET);
    assign statusHit    = offsetHit(ioRequest, GROUP1_STATUS_OFFSET);
    assign writeLanes   = laneMask(ioRequest.byteEnable);
    assign enablesWrite = ioRequest.write && enablesHit;

    assign next_enables = pwrButtonOverride ? GROUP0_ENABLES_RESET :
                          enablesWrite ?
                          ((eventGroup0Enables & ~writeLanes)
                          | (ioRequest.data & writeLanes)) & GROUP0_WRITABLE_MASK :
                          eventGroup0Enables;

    assign eventGroup0Enables = {enablesRtc, enablesResume};

    // resume-well half of the enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enablesResume <= GROUP0_ENABLES_RESET[RESUME_WELL_TOP:0];
        end else if (ce) begin
            enablesResume <= next_enables[RESUME_WELL_TOP:0];
        end
    end

    // rtc-well half: no other reset touches bits 15 to 8
    always_ff @(posedge clk or posedge rtc_well_reset) begin
        if (rtc_well_reset) begin
            enablesRtc <= GROUP0_ENABLES_RESET[15:RTC_WELL_LOW];
        end else if (ce) begin
            enablesRtc <= next_enables[15:RTC_WELL_LOW];
        end
    end

    // group1 status bits
    assign group1Clear = (ioRequest.write && statusHit) ? ioRequest.data & writeLanes
                                                        : 16'h0000;

    gpee_gp_status u_gp_status (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .pinLevel  (gpInputPin),
        .isInput   (gpInputIsInput),
        .invert    (gpInputInvert),
        .clearMask (group1Clear),
        .pinActive (gpActive),
        .flag      (gpInputFlag)
    );

    // thermal and tco flags: a set in the clearing cycle wins
    assign thermalActive       = eventGroup0Enables[THERMAL_POLARITY_BIT] ? thermalPin
                                                                          : ~thermalPin;
    assign next_thermalFlag    = thermalActive | (thermalFlag & ~thermalFlagClear);
    assign next_tcoAcpiIrqFlag = tcoAcpiIrqSet | (tcoAcpiIrqFlag & ~tcoAcpiIrqClear);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thermalFlag    <= 1'b0;
            tcoAcpiIrqFlag <= 1'b0;
            batteryLowPrev <= 1'b1;
        end else if (ce) begin
            thermalFlag    <= next_thermalFlag;
            tcoAcpiIrqFlag <= next_tcoAcpiIrqFlag;
            batteryLowPrev <= batteryLowPin;
        end
    end

    // first-group status laid out at the enable positions
    assign group0Status = {2'b00,
                           bus0MgmtEventFlag,
                           usbCtrlThreeWakeFlag,
                           mgmtEventFlag,
                           1'b0,
                           1'b0,
                           ringWakeFlag,
                           1'b0,
                           tcoAcpiIrqFlag,
                           codecWakeFlag,
                           usbCtrlTwoWakeFlag,
                           usbCtrlOneWakeFlag,
                           1'b0,
                           1'b0,
                           thermalFlag};

    assign group0Pending = group0Status & eventGroup0Enables;
    assign group1Pending = gpInputFlag & gpInputEnable;

    // wake qualification by sleep state and how S5 was entered
    assign sleeping        = sleepState != SLEEP_S0;
    assign inS5            = sleepState == SLEEP_S5;
    assign bus0WakeAllowed = sleeping && !(inS5 && s5Entry == ENTRY_OVERRIDE);
    assign mgmtWakeAllowed = sleeping && (!inS5 || s5Entry == ENTRY_SLEEP_COMMAND);

    // battery low keeps inhibiting wake whatever its enable says
    assign next_wakeRequest = batteryLowPin && (
                              (bus0WakeAllowed && group0Pending[BUS0_MGMT_BIT])
                           || (mgmtWakeAllowed && group0Pending[MGMT_EVENT_BIT])
                           || (sleeping && group0Pending[USB_THREE_BIT])
                           || (sleeping && group0Pending[RING_BIT])
                           || (sleeping && |(group0Pending
                                & WAKE_SOURCE_MASK
                                & ~(16'h0001 << BUS0_MGMT_BIT)
                                & ~(16'h0001 << MGMT_EVENT_BIT)))
                           || (sleeping && |group1Pending));

    // interrupt routing, only while running except the battery-low event, which is routed in any sleep state
    assign gpAcpiRoute     = routeMask(gpInputRouting, ROUTE_ACPI);
    assign gpMgmtRoute     = routeMask(gpInputRouting, ROUTE_SYSTEM_MGMT);
    assign batteryLowFall  = batteryLowPrev && !batteryLowPin;
    assign batteryLowEvent = batteryLowFall && eventGroup0Enables[BATTERY_LOW_BIT];
    assign routedEvent     = group0Pending[BUS0_MGMT_BIT]
                          || group0Pending[THERMAL_EVENT_BIT];

    assign next_acpiEventRequest = (batteryLowEvent && acpiRoutingSelect)
                                || (!sleeping && (
                                       group0Pending[MGMT_EVENT_BIT]
                                    || group0Pending[TCO_BIT]
                                    || (acpiRoutingSelect && routedEvent)
                                    || |(group1Pending & gpAcpiRoute)));

    assign next_systemMgmtRequest = (batteryLowEvent && !acpiRoutingSelect)
                                 || (!sleeping && (
                                        (!acpiRoutingSelect && routedEvent)
                                     || |(group1Pending & gpMgmtRoute)));

    // register read data, unmapped offsets read zero
    assign readData = enablesHit ? eventGroup0Enables :
                      statusHit  ? gpInputFlag :
                      16'h0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            groupZeroRequest  <= 16'h0000;
            groupOneRequest   <= 16'h0000;
            wakeRequest       <= 1'b0;
            acpiEventRequest  <= 1'b0;
            systemMgmtRequest <= 1'b0;
            ioResponse        <= '0;
        end else if (ce) begin
            groupZeroRequest  <= group0Pending;
            groupOneRequest   <= group1Pending;
            wakeRequest       <= next_wakeRequest;
            acpiEventRequest  <= next_acpiEventRequest;
            systemMgmtRequest <= next_systemMgmtRequest;
            ioResponse.valid  <= ioRequest.read;
            ioResponse.data   <= ioRequest.read ? readData : 16'h0000;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst || rtc_well_reset);

    sequence s_enable_write;
        ce && !pwrButtonOverride && ioRequest.write && enablesHit
           && ioRequest.byteEnable == 2'h3;
    endsequence

    sequence s_enable_read;
        ce && !pwrButtonOverride && ioRequest.read && enablesHit && !ioRequest.write;
    endsequence

    a_enable_readback: assert property (s_enable_write ##1 s_enable_read |=>
        ioResponse.valid && ioResponse.data == ($past(ioRequest.data, 2) & GROUP0_WRITABLE_MASK))
        else $error("enables read back differs from write");

    a_reserved_zero: assert property ((eventGroup0Enables & ~GROUP0_WRITABLE_MASK) == 16'h0000)
        else $error("reserved enable bit set");

    a_override_clear: assert property (ce && pwrButtonOverride |=> eventGroup0Enables == 16'h0000)
        else $error("override left an enable set");

    a_thermal_set: assert property (ce && thermalActive |=> thermalFlag)
        else $error("thermal flag missed an active pin");

    a_thermal_polarity: assert property (ce && !thermalFlag && !thermalFlagClear &&
        eventGroup0Enables[THERMAL_POLARITY_BIT] && !thermalPin |=> !thermalFlag)
        else $error("thermal flag set at inactive level");

    a_tco_set_wins: assert property (ce && tcoAcpiIrqSet && tcoAcpiIrqClear |=> tcoAcpiIrqFlag)
        else $error("tco flag lost on a clearing write");

    a_group_request: assert property (ce |=> groupZeroRequest == $past(group0Status & eventGroup0Enables))
        else $error("group zero request not status and enable");

    a_wake_sleep: assert property (ce && sleeping && batteryLowPin && |group1Pending |=> wakeRequest)
        else $error("enabled input did not wake");

    a_wake_inhibit: assert property (ce && !batteryLowPin |=> !wakeRequest)
        else $error("wake raised during battery low");

    a_tco_acpi: assert property (ce && !sleeping && tcoAcpiIrqFlag && eventGroup0Enables[TCO_BIT]
        |=> acpiEventRequest)
        else $error("enabled tco flag gave no acpi event");

    a_battery_route: assert property (ce && batteryLowEvent && !acpiRoutingSelect
        |=> systemMgmtRequest && !wakeRequest)
        else $error("battery low fall not routed to management");

    a_override_wake: assert property (ce && inS5 && s5Entry == ENTRY_OVERRIDE &&
        group0Pending == (16'h0001 << BUS0_MGMT_BIT) && group1Pending == 16'h0000 |=> !wakeRequest)
        else $error("bus0 event woke after override");

    a_usb3_wake: assert property (ce && sleeping && batteryLowPin && group0Pending[USB_THREE_BIT]
        |=> wakeRequest)
        else $error("third usb wake not raised");

endmodule

// [bench/gpee_event_gate_test.sv]
`timescale 1ns/1ps
module gpee_event_gate_test
    import gpee_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              rtc_well_reset = 1'b1;
    logic              ce = 1'b1;
    logic              override = 1'b0;
    logic              thermalPin = 1'b1;
    logic              batteryLowPin = 1'b1;
    logic              routeSel = 1'b1;
    logic              tcoSet = 1'b0;
    logic              tcoClear = 1'b0;
    logic              thermalClear = 1'b0;
    gpee_sleep_type    sleepState = SLEEP_S0;
    gpee_s5_entry_type s5Entry = ENTRY_SLEEP_COMMAND;
    gpee_io_req_type   req = '0;
    gpee_io_rsp_type   rsp;
    logic [15:0]       srcFlags = 16'h0000;
    logic [15:0]       gpPin = 16'hFFFF;
    logic [15:0]       gpIsInput = 16'hFFFF;
    logic [15:0]       gpInvert = 16'h0000;
    logic [15:0]       gpEnable = 16'h0000;
    logic [31:0]       gpRouting = 32'h0000_0000;
    logic [15:0]       enables;
    logic [15:0]       gpFlag;
    logic [15:0]       reqZero;
    logic [15:0]       reqOne;
    logic              thermalFlag;
    logic              tcoFlag;
    logic              wake;
    logic              acpiReq;
    logic              mgmtReq;
    logic [15:0]       val;
    logic [15:0]       act;
    logic [15:0]       expEn;
    logic [15:0]       d;
    logic [1:0]        be;
    int                mismatches = 0;
    int                n_tests = 0;
    int                cycles = 0;
    int                hits;
    int                wakeBits[7] = '{3, 4, 5, 8, 12, 13, 11};

    gpee_event_gate dut (.clk(clk), .rst(rst), .rtc_well_reset(rtc_well_reset), .ce(ce), .ioRequest(req),
        .ioResponse(rsp), .pwrButtonOverride(override), .thermalPin(thermalPin),
        .batteryLowPin(batteryLowPin), .acpiRoutingSelect(routeSel), .sleepState(sleepState),
        .s5Entry(s5Entry), .bus0MgmtEventFlag(srcFlags[13]), .usbCtrlThreeWakeFlag(srcFlags[12]),
        .mgmtEventFlag(srcFlags[11]), .ringWakeFlag(srcFlags[8]), .codecWakeFlag(srcFlags[5]),
        .usbCtrlTwoWakeFlag(srcFlags[4]), .usbCtrlOneWakeFlag(srcFlags[3]),
        .tcoAcpiIrqSet(tcoSet), .tcoAcpiIrqClear(tcoClear), .thermalFlagClear(thermalClear),
        .gpInputPin(gpPin), .gpInputIsInput(gpIsInput), .gpInputInvert(gpInvert),
        .gpInputEnable(gpEnable), .gpInputRouting(gpRouting), .eventGroup0Enables(enables),
        .gpInputFlag(gpFlag), .thermalFlag(thermalFlag), .tcoAcpiIrqFlag(tcoFlag),
        .groupZeroRequest(reqZero), .groupOneRequest(reqOne), .wakeRequest(wake),
        .acpiEventRequest(acpiReq), .systemMgmtRequest(mgmtReq));

    always #5 clk = ~clk;

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one register access; read data lands in val
    task automatic io(input logic wr, input logic [7:0] off, input logic [1:0] lanes,
                      input logic [15:0] data);
        @(posedge clk);
        req <= '{write: wr, read: !wr, offset: off, byteEnable: lanes, data: data};
        @(posedge clk);
        req <= '0;
        #1;
        val = rsp.data;
        if (!wr) check("read valid", 16'h0001, 16'(rsp.valid));
    endtask

    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            0: rst <= 1'b1;
            1: rtc_well_reset <= 1'b1;
            2: override <= 1'b1;
            3: tcoSet <= 1'b1;
            4: tcoClear <= 1'b1;
            default: thermalClear <= 1'b1;
        endcase
        @(posedge clk);
        {rst, rtc_well_reset, override, tcoSet, tcoClear, thermalClear} <= '0;
        cyc(1);
    endtask

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [1:0] lanes,
                                          input logic [15:0] data);
        logic [15:0] lane;
        lane = {{8{lanes[1]}}, {8{lanes[0]}}};
        return (old & ~lane) | (data & lane & 16'h3D7D);
    endfunction

    function automatic logic [15:0] routed(input logic [31:0] r, input logic [1:0] code);
        for (int k = 0; k < 16; k++) begin
            routed[k] = r[2*k +: 2] == code;
        end
    endfunction

    initial begin
        void'($urandom(72281));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rtc_well_reset <= 1'b0;
        cyc(1);
        check("enables reset", 16'h0000, enables);
        check("status reset", 16'h0000, gpFlag);
        expEn = 16'h0000;
        for (int i = 0; i < 12; i++) begin
            be = (i == 0) ? 2'h3 : 2'($urandom);
            d = (i == 0) ? 16'hFFFF : 16'($urandom);
            io(1'b1, 8'h2A, be, d);
            expEn = merge(expEn, be, d);
            check("enables", expEn, enables);
            io(1'b0, 8'h2A, 2'h3, 16'h0000);
            check("enables read", expEn, val);
        end
        io(1'b1, 8'h2B, 2'h3, 16'hFFFF);
        io(1'b0, 8'h30, 2'h3, 16'h0000);
        check("unmapped read", 16'h0000, val);
        check("unmapped write", expEn, enables);
        io(1'b1, 8'h2A, 2'h3, 16'hFFFF);
        pulse(1);
        check("rtc well", 16'h007D, enables);
        io(1'b1, 8'h2A, 2'h3, 16'hFFFF);
        pulse(0);
        check("resume well", 16'h3D00, enables);
        @(posedge clk);
        req <= '{write: 1'b1, read: 1'b0, offset: 8'h2A, byteEnable: 2'h3, data: 16'h1234};
        @(posedge clk);
        req <= '{write: 1'b0, read: 1'b1, offset: 8'h2A, byteEnable: 2'h3, data: 16'h0000};
        @(posedge clk);
        req <= '0;
        #1;
        check("back to back read", 16'h1034, rsp.data);
        pulse(2);
        check("override", 16'h0000, enables);
        @(posedge clk);
        ce <= 1'b0;
        req <= '{write: 1'b1, read: 1'b0, offset: 8'h2A, byteEnable: 2'h3, data: 16'hFFFF};
        cyc(2);
        check("frozen enables", 16'h0000, enables);
        @(posedge clk);
        ce <= 1'b1;
        req <= '0;
        cyc(1);
        check("write while frozen", 16'h0000, enables);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            gpInvert <= 16'($urandom);
            gpPin <= 16'($urandom);
            gpIsInput <= (i == 0) ? 16'hFFFF : 16'($urandom);
            gpEnable <= 16'($urandom);
            gpRouting <= 32'($urandom);
            sleepState <= SLEEP_S3;
            cyc(3);
            act = gpIsInput & ~(gpPin ^ gpInvert) & 16'hF7FF;
            check("status", act, gpFlag);
            check("group1 request", act & gpEnable, reqOne);
            check("gp wake", 16'(|(act & gpEnable)), 16'(wake));
            @(posedge clk);
            sleepState <= SLEEP_S0;
            cyc(3);
            check("acpi route", 16'(|(act & gpEnable & routed(gpRouting, 2'h2))), 16'(acpiReq));
            check("mgmt route", 16'(|(act & gpEnable & routed(gpRouting, 2'h1))), 16'(mgmtReq));
            io(1'b1, 8'h2C, 2'h3, 16'hFFFF);
            check("sticky", act, gpFlag);
            @(posedge clk);
            gpPin <= ~gpInvert;
            cyc(2);
            check("held", act, gpFlag);
            io(1'b1, 8'h2C, 2'h3, 16'hFFFF);
            check("cleared", 16'h0000, gpFlag);
        end
        for (int p = 0; p < 2; p++) begin
            io(1'b1, 8'h2A, 2'h3, 16'h0001 | 16'(p << 2));
            @(posedge clk);
            thermalPin <= p[0];
            cyc(3);
            check("thermal flag", 16'h0001, 16'(thermalFlag));
            check("thermal event", 16'h0001, 16'(acpiReq));
            io(1'b1, 8'h2A, 2'h3, 16'(p << 2));
            cyc(2);
            check("thermal gated", 16'h0000, 16'(acpiReq));
            check("thermal kept", 16'h0001, 16'(thermalFlag));
            @(posedge clk);
            thermalPin <= ~p[0];
            pulse(5);
            check("thermal clear", 16'h0000, 16'(thermalFlag));
        end
        io(1'b1, 8'h2A, 2'h3, 16'h0040);
        pulse(3);
        check("tco flag", 16'h0001, 16'(tcoFlag));
        check("tco event", 16'h0001, 16'(acpiReq));
        io(1'b1, 8'h2A, 2'h3, 16'h0000);
        cyc(2);
        check("tco gated", 16'h0000, 16'(acpiReq));
        pulse(4);
        check("tco clear", 16'h0000, 16'(tcoFlag));
        @(posedge clk);
        {tcoSet, tcoClear} <= 2'b11;
        @(posedge clk);
        {tcoSet, tcoClear} <= 2'b00;
        cyc(1);
        check("tco set wins", 16'h0001, 16'(tcoFlag));
        pulse(4);
        @(posedge clk);
        sleepState <= SLEEP_S3;
        thermalPin <= 1'b1;
        foreach (wakeBits[j]) begin
            io(1'b1, 8'h2A, 2'h3, 16'h0001 << wakeBits[j]);
            @(posedge clk);
            srcFlags <= 16'h0001 << wakeBits[j];
            cyc(3);
            check("group0 request", 16'h0001 << wakeBits[j], reqZero);
            check("source wake", 16'h0001, 16'(wake));
        end
        @(posedge clk);
        sleepState <= SLEEP_S5;
        s5Entry <= ENTRY_POWER_FAIL;
        cyc(3);
        check("mgmt wake power fail", 16'h0000, 16'(wake));
        @(posedge clk);
        s5Entry <= ENTRY_SLEEP_COMMAND;
        cyc(3);
        check("mgmt wake sleep command", 16'h0001, 16'(wake));
        @(posedge clk);
        s5Entry <= ENTRY_POWER_FAIL;
        io(1'b1, 8'h2A, 2'h3, 16'h2000);
        @(posedge clk);
        srcFlags <= 16'h2000;
        cyc(3);
        check("bus0 wake power fail", 16'h0001, 16'(wake));
        @(posedge clk);
        s5Entry <= ENTRY_OVERRIDE;
        cyc(3);
        check("bus0 wake override", 16'h0000, 16'(wake));
        io(1'b1, 8'h2A, 2'h3, 16'h0500);
        @(posedge clk);
        srcFlags <= 16'h0100;
        sleepState <= SLEEP_S3;
        cyc(3);
        check("ring wake", 16'h0001, 16'(wake));
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            routeSel <= r[0];
            batteryLowPin <= 1'b0;
            hits = 0;
            repeat (4) begin
                @(posedge clk);
                #1;
                hits += r ? int'(acpiReq === 1'b1) : int'(mgmtReq === 1'b1);
            end
            check("battery pulse", 16'h0001, 16'(hits));
            check("wake inhibited", 16'h0000, 16'(wake));
            @(posedge clk);
            batteryLowPin <= 1'b1;
        end
        complete_run();
    end
endmodule
